// ---- design/dbc_defs.svh ----
// offsets, field positions, reset values and timing figures for the dual core controller
// assumes a 125 MHz system clock and an 8-bit register port
`ifndef DBC_DEFS_SVH
`define DBC_DEFS_SVH
`define DBC_CLK_MHZ 125
`define DBC_MEAS_US 50
`define DBC_SHORT_US 1000
`define DBC_DLY_STEP_US 500
`define DBC_RAMP_STEP_NS 500
`define DBC_BOOT_CYC 16
`define DBC_CLK_TMO 8'hff
`define DBC_FREQ_MAX 5'h17
`define DBC_A_CORE_BASE 8'h00
`define DBC_A_CONFIG 8'h08
`define DBC_A_PLL 8'h09
`define DBC_A_GOOD 8'h0a
`define DBC_A_MEAS_SEL 8'h0b
`define DBC_A_LOAD_LO 8'h0c
`define DBC_A_LOAD_HI 8'h0d
`define DBC_A_FLAGS 8'h0e
`define DBC_A_MASK 8'h0f
`define DBC_A_STATUS 8'h10
`define DBC_B_ON 0
`define DBC_B_PIN 1
`define DBC_B_FPWM 2
`define DBC_B_PD 0
`define DBC_B_DITH 1
`define DBC_B_PLL 5
`define DBC_F_MEAS 0
`define DBC_F_SYNC 1
`define DBC_F_SHORT 2
`define DBC_F_GOOD 4
`define DBC_RST_CONFIG 8'h01
`define DBC_RST_MASK 8'h00
`endif

// ---- design/dbc_pkg.sv ----
// types shared by the dual core controller
// assumes nothing beyond the defines header
package dbc_pkg;
    typedef logic [7:0] dbc_byte_t;
    typedef enum logic [2:0] {
        DBC_BOOT = 3'b001,
        DBC_STBY = 3'b010,
        DBC_ACT = 3'b100
    } dbc_mode_e;
endpackage : dbc_pkg

// ---- design/dbc_top.sv ----
// control and monitoring logic for two step-down regulator cores
// assumes analog comparators and the sync pin are asynchronous to clk
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`include "dbc_defs.svh"
module dbc_top #(
    parameter int unsigned MEAS_CYC = `DBC_MEAS_US * `DBC_CLK_MHZ,
    parameter int unsigned SHORT_CYC = `DBC_SHORT_US * `DBC_CLK_MHZ,
    parameter int unsigned DLY_STEP_CYC = `DBC_DLY_STEP_US * `DBC_CLK_MHZ
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire dbc_pkg::dbc_byte_t wdata,
    input wire logic wr,
    input wire logic rd,
    output dbc_pkg::dbc_byte_t rdata,
    input wire logic enPin,
    input wire logic syncInputPin,
    input wire logic [1:0] coreLoadHigh,
    input wire logic [1:0] coreAboveFloor,
    input wire logic [1:0] coreUnderOk,
    input wire logic [1:0] coreOverOk,
    input wire logic [8:0] measCode,
    output logic [1:0] coreRun,
    output logic [1:0] coreFixedFreq,
    output logic [1:0] coreSoftStart,
    output logic [7:0] coreLevel0,
    output logic [7:0] coreLevel1,
    output logic useExtClock,
    output logic ditherActive,
    output logic pinPulldownOn,
    output logic irqOutN
);
    import dbc_pkg::*;

    localparam int unsigned RAMP_CYC = (`DBC_RAMP_STEP_NS * `DBC_CLK_MHZ) / 1000;

    // --------------------------------------------------------------
    // register state
    // --------------------------------------------------------------
    logic [2:0] coreSetupA [2];
    logic [2:0] coreRampRate [2];
    logic [7:0] coreTargetVoltage [2];
    logic [7:0] coreTiming [2];
    logic [7:0] devConfig;
    logic [5:0] pllSetup;
    logic goodWindowSelect;
    logic [7:0] mask;
    logic [5:0] flags;
    logic [8:0] loadResult;
    dbc_mode_e mode;

    logic [18:0] syncA, syncB;
    logic syncPrev;
    logic [7:0] periodCnt;
    logic extValid;
    logic [7:0] bootCnt;
    logic measBusy, measCore, measDone;
    logic [15:0] measCnt;
    logic [1:0] pinGate, pinPrev, scLatch, goodState, riseSeen, fallSeen;
    logic [19:0] dlyCnt [2];
    logic [19:0] shortCnt [2];
    logic [15:0] rampCnt [2];
    logic [7:0] level [2];
    logic [1:0] demand, ramping, validNow, shortTrip, goodEvt;
    logic syncEvt, pllEn;

    wire coreSel = (addr[7:3] == 5'h00);
    wire flagWr = wr && (addr == `DBC_A_FLAGS);
    assign pllEn = pllSetup[`DBC_B_PLL];

    // --------------------------------------------------------------
    // input synchronisers
    // --------------------------------------------------------------
    // first stage feeds only the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syncA <= 19'h00000;
            syncB <= 19'h00000;
        end else begin
            syncA <= {measCode, coreOverOk, coreUnderOk, coreAboveFloor,
                      coreLoadHigh, syncInputPin, enPin};
            syncB <= syncA;
        end
    end
    wire enS = syncB[0];
    wire clkS = syncB[1];
    wire [1:0] loadS = syncB[3:2];
    wire [1:0] floorS = syncB[5:4];
    wire [1:0] uvS = syncB[7:6];
    wire [1:0] ovS = syncB[9:8];
    wire [8:0] codeS = syncB[18:10];

    // --------------------------------------------------------------
    // register writes
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int c = 0; c < 2; c++) begin
                coreSetupA[c] <= 3'h0;
                coreRampRate[c] <= 3'h0;
                coreTargetVoltage[c] <= 8'h00;
                coreTiming[c] <= 8'h00;
            end
            devConfig <= `DBC_RST_CONFIG;
            pllSetup <= 6'h00;
            goodWindowSelect <= 1'b0;
            mask <= `DBC_RST_MASK;
        end else if (wr) begin
            if (coreSel) begin
                unique case (addr[1:0])
                    2'h0: coreSetupA[addr[2]] <= wdata[2:0];
                    2'h1: coreRampRate[addr[2]] <= wdata[2:0];
                    2'h2: coreTargetVoltage[addr[2]] <= wdata; // ramp follows
                    2'h3: coreTiming[addr[2]] <= wdata;
                endcase
            end
            if (addr == `DBC_A_CONFIG) devConfig <= wdata;
            if (addr == `DBC_A_PLL) pllSetup <= wdata[5:0];
            if (addr == `DBC_A_GOOD) goodWindowSelect <= wdata[0];
            if (addr == `DBC_A_MASK) mask <= wdata;
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            if (coreSel) begin
                unique case (addr[1:0])
                    2'h0: rdata <= {5'h00, coreSetupA[addr[2]]};
                    2'h1: rdata <= {5'h00, coreRampRate[addr[2]]};
                    2'h2: rdata <= coreTargetVoltage[addr[2]];
                    2'h3: rdata <= coreTiming[addr[2]];
                endcase
            end else begin
                unique case (addr)
                    `DBC_A_CONFIG: rdata <= devConfig;
                    `DBC_A_PLL: rdata <= {2'h0, pllSetup};
                    `DBC_A_GOOD: rdata <= {7'h00, goodWindowSelect};
                    `DBC_A_MEAS_SEL: rdata <= {7'h00, measCore};
                    `DBC_A_LOAD_LO: rdata <= loadResult[7:0];
                    `DBC_A_LOAD_HI: rdata <= {7'h00, loadResult[8]};
                    `DBC_A_FLAGS: rdata <= {2'h0, flags};
                    `DBC_A_MASK: rdata <= mask;
                    `DBC_A_STATUS: rdata <= {(mode == DBC_ACT), ramping, coreRun,
                                             extValid, goodState};
                    default: rdata <= 8'h00;
                endcase
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    // --------------------------------------------------------------
    // load-current measurement
    // --------------------------------------------------------------
    // any select write restarts the sequence on the chosen core
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            measBusy <= 1'b0;
            measCore <= 1'b0;
            measCnt <= 16'h0000;
            measDone <= 1'b0;
            loadResult <= 9'h000;
        end else begin
            measDone <= 1'b0;
            if (wr && addr == `DBC_A_MEAS_SEL) begin
                measBusy <= 1'b1;
                measCore <= wdata[0];
                measCnt <= 16'h0000;
            end else if (measBusy) begin
                measCnt <= measCnt + 16'h0001;
                if (measCnt == 16'(MEAS_CYC - 1)) begin
                    measBusy <= 1'b0;
                    measDone <= 1'b1;
                    loadResult <= codeS; // held until next end
                end
            end
        end
    end

    // --------------------------------------------------------------
    // sync clock detector
    // --------------------------------------------------------------
    wire [5:0] nomMhz = {1'b0, pllSetup[4:0]} + 6'h01;
    wire [17:0] prod = 18'(periodCnt) * 18'(nomMhz); // widen first, the product outgrows 8 bits
    wire periodOk = (pllSetup[4:0] <= `DBC_FREQ_MAX) &&
                    (18'(prod * 18'd9) <= 18'd1250) &&
                    (18'(prod * 18'd11) >= 18'd1250);
    wire clkRise = clkS && !syncPrev;

    // detector idles with the pll bit clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syncPrev <= 1'b0;
            periodCnt <= 8'h00;
            extValid <= 1'b0;
        end else begin
            syncPrev <= clkS;
            if (!pllEn) begin
                periodCnt <= 8'h00;
                extValid <= 1'b0;
            end else if (clkRise) begin
                periodCnt <= 8'h01;
                extValid <= periodOk;
            end else if (periodCnt == `DBC_CLK_TMO) begin
                extValid <= 1'b0; // clock gone
            end else begin
                periodCnt <= periodCnt + 8'h01;
            end
        end
    end

    // --------------------------------------------------------------
    // device mode
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode <= DBC_BOOT;
            bootCnt <= 8'h00;
        end else begin
            unique case (mode)
                DBC_BOOT: begin
                    bootCnt <= bootCnt + 8'h01;
                    if (bootCnt == 8'(`DBC_BOOT_CYC)) mode <= DBC_STBY;
                end
                DBC_STBY: if (demand != 2'b00) mode <= DBC_ACT;
                DBC_ACT: if (demand == 2'b00) mode <= DBC_STBY;
            endcase
        end
    end
    wire missAtStep = pllEn && !extValid &&
                      ((mode == DBC_BOOT && bootCnt == 8'(`DBC_BOOT_CYC)) ||
                       (mode == DBC_STBY && demand != 2'b00));
    assign syncEvt = missAtStep || (pllEn && (periodOk != extValid) &&
                     (clkRise || periodCnt == `DBC_CLK_TMO));

    // --------------------------------------------------------------
    // enable path: pin delays, register bit acts at once
    // --------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            demand[c] = coreSetupA[c][`DBC_B_ON] &&
                        (!coreSetupA[c][`DBC_B_PIN] || pinGate[c]);
            validNow[c] = coreRun[c] && uvS[c] &&
                          (!goodWindowSelect || ovS[c]);
            ramping[c] = coreRun[c] && floorS[c] && (level[c] != coreTargetVoltage[c]);
            shortTrip[c] = coreRun[c] && !floorS[c] && shortCnt[c] == 20'(SHORT_CYC - 1);
            goodEvt[c] = validNow[c] != goodState[c];
        end
    end

    // pin edges reload the delay counter, gate flips on expiry
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinPrev <= 2'b00;
            pinGate <= 2'b00;
            for (int c = 0; c < 2; c++) dlyCnt[c] <= 20'h00000;
        end else begin
            for (int c = 0; c < 2; c++) begin
                pinPrev[c] <= enS;
                if (enS != pinPrev[c]) begin
                    dlyCnt[c] <= enS ? 20'(coreTiming[c][7:4] * DLY_STEP_CYC)
                                     : 20'(coreTiming[c][3:0] * DLY_STEP_CYC);
                end else if (dlyCnt[c] != 20'h00000) begin
                    dlyCnt[c] <= dlyCnt[c] - 20'h00001;
                end else begin
                    pinGate[c] <= pinPrev[c];
                end
            end
        end
    end

    // --------------------------------------------------------------
    // run, short detection, soft-start and ramp
    // --------------------------------------------------------------
    // a trip holds the core off until software or the pin drops demand
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            coreRun <= 2'b00;
            scLatch <= 2'b00;
            coreSoftStart <= 2'b00;
            for (int c = 0; c < 2; c++) shortCnt[c] <= 20'h00000;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (!demand[c]) scLatch[c] <= 1'b0;
                else if (shortTrip[c]) scLatch[c] <= 1'b1;
                coreRun[c] <= demand[c] && !scLatch[c] && !shortTrip[c] &&
                              mode != DBC_BOOT;
                coreSoftStart[c] <= demand[c] && !scLatch[c] && !floorS[c];
                if (coreRun[c] && !floorS[c]) shortCnt[c] <= shortCnt[c] + 20'h00001;
                else shortCnt[c] <= 20'h00000;
            end
        end
    end

    // one code per step, step spacing doubles with each rate code
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int c = 0; c < 2; c++) begin
                level[c] <= 8'h00;
                rampCnt[c] <= 16'h0000;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (!coreRun[c]) begin
                    level[c] <= 8'h00;
                    rampCnt[c] <= 16'h0000;
                end else if (ramping[c]) begin // held during soft-start
                    if (rampCnt[c] >= 16'(RAMP_CYC << coreRampRate[c])) begin
                        rampCnt[c] <= 16'h0000;
                        level[c] <= (level[c] < coreTargetVoltage[c]) ? level[c] + 8'h01
                                                                      : level[c] - 8'h01;
                    end else begin
                        rampCnt[c] <= rampCnt[c] + 16'h0001;
                    end
                end
            end
        end
    end
    assign coreLevel0 = level[0];
    assign coreLevel1 = level[1];

    // --------------------------------------------------------------
    // mode and clock outputs
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            coreFixedFreq <= 2'b00;
            useExtClock <= 1'b0;
            ditherActive <= 1'b0;
            pinPulldownOn <= 1'b0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                coreFixedFreq[c] <= coreSetupA[c][`DBC_B_FPWM] || loadS[c]
                                    || (measBusy && measCore == 1'(c))
                                    || ramping[c];
            end
            useExtClock <= pllEn && extValid;
            ditherActive <= devConfig[`DBC_B_DITH] && !pllEn;
            pinPulldownOn <= devConfig[`DBC_B_PD];
        end
    end

    // --------------------------------------------------------------
    // flags, power-good and interrupt line
    // --------------------------------------------------------------
    // set beats a same-cycle write-one clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags <= 6'h00;
            goodState <= 2'b00;
            riseSeen <= 2'b00;
            fallSeen <= 2'b00;
        end else begin
            goodState <= validNow;
            flags[`DBC_F_MEAS] <= measDone || (flags[`DBC_F_MEAS] && !(flagWr && wdata[`DBC_F_MEAS]));
            flags[`DBC_F_SYNC] <= syncEvt || (flags[`DBC_F_SYNC] && !(flagWr && wdata[`DBC_F_SYNC]));
            for (int c = 0; c < 2; c++) begin
                flags[`DBC_F_SHORT + c] <= shortTrip[c] ||
                    (flags[`DBC_F_SHORT + c] && !(flagWr && wdata[`DBC_F_SHORT + c]));
                flags[`DBC_F_GOOD + c] <= goodEvt[c] ||
                    (flags[`DBC_F_GOOD + c] && !(flagWr && wdata[`DBC_F_GOOD + c]));
                if (goodEvt[c] && validNow[c]) riseSeen[c] <= 1'b1;
                else if (flagWr && wdata[`DBC_F_GOOD + c]) riseSeen[c] <= 1'b0;
                if (goodEvt[c] && !validNow[c]) fallSeen[c] <= 1'b1;
                else if (flagWr && wdata[`DBC_F_GOOD + c]) fallSeen[c] <= 1'b0;
            end
        end
    end

    wire [1:0] goodIrq = {flags[5] && ((riseSeen[1] && !mask[4]) || (fallSeen[1] && !mask[5])),
                          flags[4] && ((riseSeen[0] && !mask[2]) || (fallSeen[0] && !mask[3]))};
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) irqOutN <= 1'b1;
        else irqOutN <= !((flags[0] && !mask[0]) || (flags[1] && !mask[1])
                          || flags[2] || flags[3] || goodIrq != 2'b00);
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    // busy length for the measurement bound; a restart opens a fresh sequence
    logic [15:0] measLen;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            measLen <= 16'h0000;
        end else if (!measBusy || (wr && addr == `DBC_A_MEAS_SEL)) begin
            measLen <= 16'h0000;
        end else begin
            measLen <= measLen + 16'h0001;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_ramp_pwm: assert property (ramping[0] |=> coreFixedFreq[0])
        else $error("core 0 ramping without fixed frequency");
    a_meas_length: assert property (measLen <= 16'(MEAS_CYC))
        else $error("measurement overran");
    a_meas_flag: assert property ($fell(measBusy) |=> flags[0])
        else $error("measurement end did not flag");
    a_irq_release: assert property (flags == 6'h00 |=> irqOutN)
        else $error("irq held with no flag pending");
    a_dither_pll: assert property (pllEn |=> !ditherActive)
        else $error("dither active with pll enabled");
    a_ext_off: assert property (!pllEn |=> !useExtClock && !$rose(flags[1]))
        else $error("external clock used with pll off");
    a_ramp_step: assert property (coreRun[0] && $past(coreRun[0]) && $changed(level[0])
        |-> (level[0] - $past(level[0]) == 8'h01) || ($past(level[0]) - level[0] == 8'h01))
        else $error("output level stepped");
    a_short_off: assert property ($rose(flags[2]) |-> !coreRun[0])
        else $error("core 0 still running after short");
    a_reg_enable: assert property (wr && addr == 8'h00 && wdata[1:0] == 2'b01 && mode != DBC_BOOT
        && !scLatch[0] |-> ##[1:2] coreRun[0])
        else $error("register enable delayed");
    c_meas_done: cover property ($fell(measBusy));
    c_ext_valid: cover property ($rose(useExtClock));
    c_short_trip: cover property ($rose(flags[2]));
endmodule : dbc_top

// ---- verification/dbc_power_model.sv ----
// far-side model: power stage comparators and the external sync clock source
// assumes the bench asks for a short and for the sync clock by plain levels
module dbc_power_model (
    input wire logic [1:0] coreRun,
    input wire logic shortCore,
    input wire logic syncOn,
    output logic [1:0] coreAboveFloor,
    output logic [1:0] coreUnderOk,
    output logic [1:0] coreOverOk,
    output logic syncInputPin
);
    timeunit 1ns;
    timeprecision 100ps;
    // output climbs only while the stage runs; a short pins core 0 low
    assign coreAboveFloor = coreRun & {1'b1, ~shortCore};
    assign coreUnderOk = coreAboveFloor;
    assign coreOverOk = 2'b11;
    // 12.5 MHz, phase unrelated to clk; stands still outside use
    initial begin
        syncInputPin = 1'b0;
        #13;
        forever begin
            #40 syncInputPin = syncOn ? ~syncInputPin : 1'b0;
        end
    end
endmodule : dbc_power_model

// ---- verification/tb_dbc_top.sv ----
// testbench for dbc_top: register port tasks and scenarios with expected values
// assumes the power model beside it; long counts shortened by parameters
module tb_dbc_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dbc_pkg::*;
    localparam int MC = 20;
    localparam int SC = 50;
    logic clk = 0, nrst = 0, wr = 0, rd = 0, enPin = 0, syncOn = 0, shortCore = 0;
    logic [7:0] addr = 8'h00;
    dbc_byte_t wdata = 8'h00;
    dbc_byte_t rdata;
    logic [1:0] coreLoadHigh = 2'b00, coreAboveFloor, coreUnderOk, coreOverOk, coreRun, coreFixedFreq, coreSoftStart;
    logic [8:0] measCode = 9'h1a5;
    logic [7:0] coreLevel0, coreLevel1;
    logic syncInputPin, useExtClock, ditherActive, pinPulldownOn, irqOutN;
    int err_total = 0, comparisons = 0;
    dbc_top #(.MEAS_CYC(MC), .SHORT_CYC(SC), .DLY_STEP_CYC(10)) i_dut (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .enPin(enPin), .syncInputPin(syncInputPin),
        .coreLoadHigh(coreLoadHigh), .coreAboveFloor(coreAboveFloor), .coreUnderOk(coreUnderOk),
        .coreOverOk(coreOverOk), .measCode(measCode), .coreRun(coreRun), .coreFixedFreq(coreFixedFreq),
        .coreSoftStart(coreSoftStart), .coreLevel0(coreLevel0), .coreLevel1(coreLevel1),
        .useExtClock(useExtClock), .ditherActive(ditherActive), .pinPulldownOn(pinPulldownOn), .irqOutN(irqOutN));
    dbc_power_model i_model (.coreRun(coreRun), .shortCore(shortCore), .syncOn(syncOn),
        .coreAboveFloor(coreAboveFloor), .coreUnderOk(coreUnderOk), .coreOverOk(coreOverOk),
        .syncInputPin(syncInputPin));
    // ---------------------------------------------------------------
    // clock, tasks, verdict
    // ---------------------------------------------------------------
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // one-cycle strobes, changed just after the edge
    task automatic wr_reg(input logic [7:0] a, input dbc_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input dbc_byte_t exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", {1'b0, exp}, {1'b0, rdata});
    endtask : rd_reg
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc
    task automatic final_report;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    // hang guard, far beyond the few thousand cycles the tests need
    initial begin
        #200000;
        err_total++;
        final_report;
    end
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        wait_cyc(20);
        rd_reg(8'h08, 8'h01);
        chk("pulldown", 1, pinPulldownOn);
        wr_reg(8'h08, 8'h00);
        wait_cyc(2);
        chk("pulldown", 0, pinPulldownOn);
        rd_reg(8'h10, 8'h00);
        // measurement on core 0, result split low byte and top bit
        wr_reg(8'h0b, 8'h00);
        wait_cyc(1);
        chk("fixed0 meas", 1, coreFixedFreq[0]);
        wait_cyc(MC + 2);
        chk("irq meas", 0, irqOutN);
        rd_reg(8'h0e, 8'h01);
        rd_reg(8'h0c, 8'ha5);
        rd_reg(8'h0d, 8'h01);
        chk("fixed0 idle", 0, coreFixedFreq[0]);
        wr_reg(8'h0f, 8'h01);
        wait_cyc(2);
        chk("irq masked", 1, irqOutN);
        wr_reg(8'h0e, 8'h01);
        wr_reg(8'h0f, 8'h00);
        measCode <= 9'h033;
        wait_cyc(3);
        chk("irq cleared", 1, irqOutN);
        rd_reg(8'h0c, 8'ha5);
        @(posedge clk);
        coreLoadHigh <= 2'b01;
        wait_cyc(6);
        chk("fixed0 load", 1, coreFixedFreq[0]);
        @(posedge clk);
        coreLoadHigh <= 2'b00;
        // register enable acts at once, then ramps to target
        wr_reg(8'h02, 8'h40);
        wr_reg(8'h00, 8'h01);
        wait_cyc(2);
        chk("run0", 1, coreRun[0]);
        chk("soft0", 1, coreSoftStart[0]);
        wait_cyc(200);
        chk("soft0 done", 0, coreSoftStart[0]);
        chk("fixed0 ramp", 1, coreFixedFreq[0]);
        chk("no step", 1, coreLevel0 < 8'h40);
        wait_cyc(4200);
        chk("level0", 9'h040, coreLevel0);
        chk("fixed0 done", 0, coreFixedFreq[0]);
        rd_reg(8'h10, 8'h89);
        rd_reg(8'h0e, 8'h10);
        chk("irq good", 0, irqOutN);
        wr_reg(8'h0e, 8'hff);
        // short on core 0: disable after the debounce count
        shortCore <= 1'b1;
        wait_cyc(SC + 12);
        chk("run0 short", 0, coreRun[0]);
        rd_reg(8'h0e, 8'h14);
        wr_reg(8'h00, 8'h00);
        shortCore <= 1'b0;
        wr_reg(8'h0e, 8'hff);
        // sync clock 12.5 MHz against 12 MHz nominal
        wr_reg(8'h08, 8'h02);
        wr_reg(8'h09, 8'h2b);
        syncOn <= 1'b1;
        wait_cyc(100);
        chk("ext clock", 1, useExtClock);
        chk("dither pll", 0, ditherActive);
        rd_reg(8'h0e, 8'h02);
        wr_reg(8'h09, 8'h20);
        wait_cyc(100);
        chk("ext off nominal", 0, useExtClock);
        // pin control on core 1, pll on with no valid sync clock at the step to active
        wr_reg(8'h0e, 8'hff);
        wr_reg(8'h07, 8'h21);
        wr_reg(8'h06, 8'h03);
        wr_reg(8'h04, 8'h03);
        enPin <= 1'b1;
        wait_cyc(15);
        chk("run1 rise delay", 0, coreRun[1]);
        wait_cyc(20);
        chk("run1 pin", 1, coreRun[1]);
        rd_reg(8'h0e, 8'h22);
        wait_cyc(250);
        chk("level1", 9'h003, coreLevel1);
        @(posedge clk);
        enPin <= 1'b0;
        wait_cyc(5);
        chk("run1 fall delay", 1, coreRun[1]);
        wait_cyc(20);
        chk("run1 off", 0, coreRun[1]);
        wr_reg(8'h09, 8'h00);
        wait_cyc(4);
        chk("dither rc", 1, ditherActive);
        final_report;
    end
endmodule : tb_dbc_top
